// >>> verilog/twm_pkg.sv
// Shared constants and types of the two-wire master transmitter.
package twm_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] DATA_RESET = 8'hFF;

  // ==========================================================================
  // Status codes, prescaler bits always zero
  // ==========================================================================
  localparam logic [7:0] STAT_START = 8'h08;
  localparam logic [7:0] STAT_RSTART = 8'h10;
  localparam logic [7:0] STAT_AW_ACK = 8'h18;
  localparam logic [7:0] STAT_AW_NACK = 8'h20;
  localparam logic [7:0] STAT_DW_ACK = 8'h28;
  localparam logic [7:0] STAT_DW_NACK = 8'h30;
  localparam logic [7:0] STAT_LOST = 8'h38;
  localparam logic [7:0] STAT_AR_ACK = 8'h40;
  localparam logic [7:0] STAT_AR_NACK = 8'h48;
  localparam logic [7:0] STAT_DR_ACK = 8'h50;
  localparam logic [7:0] STAT_DR_NACK = 8'h58;
  localparam logic [7:0] STAT_NONE = 8'hF8;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_PERIOD_NS = 800;
  localparam int QUARTER_CYC = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic flag;
    logic ack_en;
    logic start;
    logic stop;
    logic wc;
    logic en;
    logic rsv;
    logic ie;
  } twm_ctrl_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } twm_line_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_FREE,
    ST_START,
    ST_SEND,
    ST_STOP,
    ST_HOLD
  } twm_state_e;

endpackage

// >>> verilog/twm_sync.sv
// Two-flop synchroniser for the bus line inputs.
`timescale 1ns/10ps
module twm_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '1;
      q <= '1;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

// >>> verilog/twm_master.sv
// Two-wire master transmitter with APB register access.
//
// Contract
// [R1] START request waits for a free bus, then generates START.
// [R2] After START the flag sets and status reads $08.
// [R3] Address write bit selects transmitter mode, read bit receiver mode.
// [R4] Software masks prescaler bits before comparing status codes.
// [R5] Software loads address plus write bit, then clears flag.
// [R6] Address acknowledge gives $18, no acknowledge $20, lost arbitration $38.
// [R7] Data writes while flag low are discarded and set write collision.
// [R8] Writing one to the flag clears it and starts the next action.
// [R9] Stop request generates STOP; hardware then clears the stop bit.
// [R10] Start request during a transfer generates repeated START, status $10.
// [R11] After repeated START the bus stays owned; any address may follow.
// [R12] In $08 clearing the flag sends the loaded address and samples acknowledge.
// [R13] In $10 a read address enters receiver mode, write stays transmitter.
// [R14] Data byte acknowledged gives $28, not acknowledged gives $30.
// [R15] In $18-$30 clearing with start and stop zero sends the data byte.
// [R16] In $18-$30 clearing with start one sends a repeated START.
// [R17] In $18-$30 clearing with stop one sends STOP and clears stop.
// [R18] In $18-$30 start and stop both one send STOP then START.
// [R19] In $38 start zero releases the bus; start one restarts when free.
// [R20] Software keeps the enable bit one in every control write.
// [R21] Transfer stays suspended while the flag is set.
// [R22] Interrupt request follows flag and interrupt enable together.
// [R23] While suspended as owner the clock line is held low.
`timescale 1ns/10ps
module twm_master #(
  parameter int QUARTER_CYC = twm_pkg::QUARTER_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [twm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic IRQ
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (QUARTER_CYC < 1 || QUARTER_CYC > 256) begin : g_bad_quarter
    $error("QUARTER_CYC must lie between 1 and 256");
  end

  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);

  // ==========================================================================
  // Line synchronisers and bus state detection
  // ==========================================================================
  twm_pkg::twm_line_s line_raw;
  twm_pkg::twm_line_s line_s;
  logic prev_sda;
  logic start_seen;
  logic stop_seen;

  assign line_raw = '{scl: SCL_IN, sda: SDA_IN};

  twm_sync #(.W(2)) u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .d(line_raw),
    .q(line_s)
  );

  assign start_seen = line_s.scl && prev_sda && !line_s.sda;
  assign stop_seen = line_s.scl && !prev_sda && line_s.sda;

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic access;
  logic hit;
  logic wr_ctrl;
  logic wr_data;
  logic [31:0] rd_mux;
  twm_pkg::twm_ctrl_s wctl;
  twm_pkg::twm_ctrl_s ctl;
  logic [7:0] data;
  logic [7:0] status;

  assign access = PSEL && PENABLE && PREADY;
  assign hit = PADDR == twm_pkg::OFS_CTRL || PADDR == twm_pkg::OFS_DATA ||
               PADDR == twm_pkg::OFS_STATUS;
  assign wr_ctrl = access && PWRITE && PADDR == twm_pkg::OFS_CTRL;
  assign wr_data = access && PWRITE && PADDR == twm_pkg::OFS_DATA;
  assign wctl = twm_pkg::twm_ctrl_s'(PWDATA[7:0]);

  always_comb begin
    rd_mux = 32'h00000000;
    case (PADDR)
      twm_pkg::OFS_CTRL: rd_mux = {24'h000000, ctl};
      twm_pkg::OFS_DATA: rd_mux = {24'h000000, data};
      twm_pkg::OFS_STATUS: rd_mux = {24'h000000, status};
      default: rd_mux = 32'h00000000;
    endcase
    next_pready = PSEL && !PENABLE;
    next_pslverr = PSEL && !PENABLE && !hit;
    next_prdata = (PSEL && !PENABLE && !PWRITE) ? rd_mux : PRDATA;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      PRDATA <= next_prdata;
    end
  end

  // ==========================================================================
  // Transfer engine
  // ==========================================================================
  twm_pkg::twm_state_e state;
  twm_pkg::twm_state_e next_state;
  twm_pkg::twm_ctrl_s next_ctl;
  logic [1:0] q;
  logic [1:0] next_q;
  logic [7:0] div;
  logic [7:0] next_div;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] next_data;
  logic [7:0] next_status;
  logic active;
  logic next_active;
  logic addr_phase;
  logic next_addr_phase;
  logic rx_mode;
  logic next_rx_mode;
  logic ack_seen;
  logic next_ack_seen;
  logic busy;
  logic next_busy;
  logic next_scl_oe_n;
  logic next_sda_oe_n;
  logic next_irq;
  logic running;
  logic tick;
  logic adv;
  logic q_end;
  logic go;
  logic rx_data;
  logic flag_set;

  assign running = state == twm_pkg::ST_START || state == twm_pkg::ST_SEND ||
                   state == twm_pkg::ST_STOP;
  assign tick = running && div == QUARTER_LAST;
  // Quarter one ends only once the clock line is seen high, so a slave may stretch.
  assign adv = tick && (q != 2'h1 || line_s.scl);
  assign q_end = adv && q == 2'h3;
  assign go = wr_ctrl && wctl.flag && wctl.en; // [R8]
  assign rx_data = rx_mode && !addr_phase;

  always_comb begin
    next_state = state;
    next_ctl = ctl;
    next_q = q;
    next_div = running ? (tick ? 8'h00 : div + 8'h01) : 8'h00;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_data = data;
    next_status = status;
    next_active = active;
    next_addr_phase = addr_phase;
    next_rx_mode = rx_mode;
    next_ack_seen = ack_seen;
    next_scl_oe_n = SCL_OE_N;
    next_sda_oe_n = SDA_OE_N;
    next_busy = start_seen ? 1'b1 : (stop_seen ? 1'b0 : busy);
    next_irq = ctl.flag && ctl.ie; // [R22]
    flag_set = 1'b0;
    if (adv) begin
      next_q = q + 2'h1;
    end
    if (wr_ctrl) begin
      next_ctl.ack_en = wctl.ack_en;
      next_ctl.start = wctl.start;
      next_ctl.stop = wctl.stop;
      next_ctl.en = wctl.en;
      next_ctl.ie = wctl.ie;
      if (wctl.flag) begin
        next_ctl.flag = 1'b0; // [R8]
      end
    end
    if (wr_data) begin
      if (ctl.flag) begin
        next_data = PWDATA[7:0];
        next_ctl.wc = 1'b0;
      end else begin
        next_ctl.wc = 1'b1; // [R7]
      end
    end
    case (state)
      twm_pkg::ST_IDLE: begin
        if (go && wctl.start) begin
          next_state = twm_pkg::ST_WAIT_FREE; // [R1]
        end
      end
      twm_pkg::ST_WAIT_FREE: begin
        if (!busy && line_s.scl && line_s.sda) begin
          next_state = twm_pkg::ST_START; // [R1]
          next_q = 2'h0;
          next_sda_oe_n = 1'b1;
        end
      end
      twm_pkg::ST_START: begin
        if (adv) begin
          case (q)
            2'h0: next_scl_oe_n = 1'b1;
            2'h1: next_sda_oe_n = 1'b0;
            2'h2: next_scl_oe_n = 1'b0;
            default: begin
              next_status = active ? twm_pkg::STAT_RSTART : twm_pkg::STAT_START; // [R2] [R10]
              next_active = 1'b1; // [R11]
              next_addr_phase = 1'b1;
              flag_set = 1'b1;
              next_state = twm_pkg::ST_HOLD;
            end
          endcase
        end
      end
      twm_pkg::ST_SEND: begin
        if (adv) begin
          case (q)
            2'h0: next_scl_oe_n = 1'b1;
            2'h1: begin
              if (bitcnt == twm_pkg::ACK_BIT) begin
                next_ack_seen = !line_s.sda; // [R12]
              end else begin
                next_shreg = {shreg[6:0], line_s.sda};
                if (!rx_data && SDA_OE_N && !line_s.sda) begin
                  next_status = twm_pkg::STAT_LOST; // [R6]
                  next_active = 1'b0;
                  next_scl_oe_n = 1'b1;
                  next_sda_oe_n = 1'b1;
                  flag_set = 1'b1;
                  next_state = twm_pkg::ST_HOLD;
                end
              end
            end
            2'h2: next_scl_oe_n = 1'b0;
            default: begin
              if (bitcnt == twm_pkg::ACK_BIT) begin
                next_sda_oe_n = 1'b1;
                next_addr_phase = 1'b0;
                flag_set = 1'b1;
                next_state = twm_pkg::ST_HOLD;
                if (addr_phase) begin
                  next_rx_mode = shreg[0]; // [R3] [R13]
                  if (shreg[0]) begin
                    next_status = ack_seen ? twm_pkg::STAT_AR_ACK : twm_pkg::STAT_AR_NACK;
                  end else begin
                    next_status = ack_seen ? twm_pkg::STAT_AW_ACK : twm_pkg::STAT_AW_NACK; // [R6]
                  end
                end else if (rx_mode) begin
                  next_data = shreg;
                  next_status = ctl.ack_en ? twm_pkg::STAT_DR_ACK : twm_pkg::STAT_DR_NACK;
                end else begin
                  next_status = ack_seen ? twm_pkg::STAT_DW_ACK : twm_pkg::STAT_DW_NACK; // [R14]
                end
              end else begin
                next_bitcnt = bitcnt + 4'h1;
                if (bitcnt == twm_pkg::LAST_DATA_BIT) begin
                  next_sda_oe_n = rx_data ? !ctl.ack_en : 1'b1;
                end else begin
                  next_sda_oe_n = rx_data ? 1'b1 : shreg[7];
                end
              end
            end
          endcase
        end
      end
      twm_pkg::ST_STOP: begin
        if (adv) begin
          case (q)
            2'h0: next_scl_oe_n = 1'b1;
            2'h1: next_sda_oe_n = 1'b1;
            2'h2: next_sda_oe_n = 1'b1;
            default: begin
              next_ctl.stop = 1'b0; // [R9] [R17]
              next_active = 1'b0;
              next_state = ctl.start ? twm_pkg::ST_WAIT_FREE : twm_pkg::ST_IDLE; // [R18]
            end
          endcase
        end
      end
      twm_pkg::ST_HOLD: begin
        // The engine waits here, clock held low by the owner, until the flag clears.
        if (go) begin // [R21] [R23]
          next_q = 2'h0;
          next_div = 8'h00;
          if (wctl.stop && active) begin
            next_state = twm_pkg::ST_STOP; // [R9] [R17] [R18]
            next_sda_oe_n = 1'b0;
          end else if (wctl.start) begin
            if (active) begin
              next_state = twm_pkg::ST_START; // [R10] [R16]
              next_sda_oe_n = 1'b1;
            end else begin
              next_state = twm_pkg::ST_WAIT_FREE; // [R19]
            end
          end else if (active) begin
            next_state = twm_pkg::ST_SEND; // [R12] [R15]
            next_shreg = data;
            next_bitcnt = 4'h0;
            next_sda_oe_n = rx_data ? 1'b1 : data[7];
          end else begin
            next_state = twm_pkg::ST_IDLE; // [R19]
            next_scl_oe_n = 1'b1;
            next_sda_oe_n = 1'b1;
          end
        end
      end
      default: next_state = twm_pkg::ST_IDLE;
    endcase
    if (flag_set) begin
      next_ctl.flag = 1'b1;
    end
    if (!next_ctl.en) begin
      next_state = twm_pkg::ST_IDLE;
      next_active = 1'b0;
      next_scl_oe_n = 1'b1;
      next_sda_oe_n = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= twm_pkg::ST_IDLE;
      ctl <= '0;
      q <= 2'h0;
      div <= 8'h00;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      data <= twm_pkg::DATA_RESET;
      status <= twm_pkg::STAT_NONE;
      active <= 1'b0;
      addr_phase <= 1'b0;
      rx_mode <= 1'b0;
      ack_seen <= 1'b0;
      busy <= 1'b0;
      prev_sda <= 1'b1;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
      q <= next_q;
      div <= next_div;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      data <= next_data;
      status <= next_status;
      active <= next_active;
      addr_phase <= next_addr_phase;
      rx_mode <= next_rx_mode;
      ack_seen <= next_ack_seen;
      busy <= next_busy;
      prev_sda <= line_s.sda;
      SCL_OE_N <= next_scl_oe_n;
      SDA_OE_N <= next_sda_oe_n;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      IRQ <= next_irq;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_start_code: assert property (state == twm_pkg::ST_START && q_end && !active |=> // [R2]
    ctl.flag && status == twm_pkg::STAT_START && state == twm_pkg::ST_HOLD)
    else $error("START did not report 08");
  a_rstart_code: assert property (state == twm_pkg::ST_START && q_end && active |=> // [R10]
    status == twm_pkg::STAT_RSTART && active)
    else $error("Repeated START did not report 10");
  a_addr_code: assert property (state == twm_pkg::ST_SEND && q_end && // [R6]
    bitcnt == twm_pkg::ACK_BIT && addr_phase && !shreg[0] |=>
    status == ($past(ack_seen) ? twm_pkg::STAT_AW_ACK : twm_pkg::STAT_AW_NACK))
    else $error("Wrong address status code");
  a_data_code: assert property (state == twm_pkg::ST_SEND && q_end && // [R14]
    bitcnt == twm_pkg::ACK_BIT && !addr_phase && !rx_mode |=>
    status == ($past(ack_seen) ? twm_pkg::STAT_DW_ACK : twm_pkg::STAT_DW_NACK))
    else $error("Wrong data status code");
  a_wc_discard: assert property (wr_data && !ctl.flag |=> ctl.wc && data == $past(data)) // [R7]
    else $error("Data write with flag low was not discarded");
  a_flag_clear: assert property (go && state == twm_pkg::ST_HOLD |=> !ctl.flag) // [R8]
    else $error("Flag not cleared by writing one");
  a_stop_clear: assert property (state == twm_pkg::ST_STOP && q_end |=> // [R9]
    !ctl.stop && !active && SDA_OE_N && SCL_OE_N)
    else $error("STOP did not clear the stop bit");
  a_hold_susp: assert property (state == twm_pkg::ST_HOLD && !go && ctl.en |=> // [R21]
    state == twm_pkg::ST_HOLD && $stable(status))
    else $error("Transfer moved while suspended");
  a_hold_scl: assert property (state == twm_pkg::ST_HOLD && active [*2] |-> !SCL_OE_N) // [R23]
    else $error("Clock line not held low while suspended");
  a_irq_level: assert property (ctl.flag && ctl.ie ##1 ctl.flag |-> IRQ) // [R22]
    else $error("Interrupt request missing");
  a_wait_free: assert property (state == twm_pkg::ST_WAIT_FREE && busy && ctl.en |=> // [R1]
    state == twm_pkg::ST_WAIT_FREE)
    else $error("START issued on a busy bus");
  a_lost_release: assert property (state == twm_pkg::ST_HOLD && // [R19]
    status == twm_pkg::STAT_LOST |-> SCL_OE_N && SDA_OE_N && !active)
    else $error("Bus not released after lost arbitration");
  a_send_load: assert property (go && state == twm_pkg::ST_HOLD && active && // [R15]
    !wctl.start && !wctl.stop |=> state == twm_pkg::ST_SEND && shreg == $past(data))
    else $error("Data byte not loaded for sending");
  a_mode_sel: assert property (state == twm_pkg::ST_SEND && q_end && // [R3]
    bitcnt == twm_pkg::ACK_BIT && addr_phase |=> rx_mode == $past(shreg[0]))
    else $error("Mode not taken from the address direction bit");

  c_start: cover property (state == twm_pkg::ST_HOLD && status == twm_pkg::STAT_START);
  c_data_ack: cover property (state == twm_pkg::ST_HOLD && status == twm_pkg::STAT_DW_ACK);
  c_lost: cover property (status == twm_pkg::STAT_LOST);
  c_stop: cover property (state == twm_pkg::ST_STOP ##1 state == twm_pkg::ST_IDLE);

endmodule

// >>> bench/twm_slave_model.sv
// Behavioural slave receiver on the open-drain two-wire bus.
`timescale 1ns/10ps
module twm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic stretch,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic [7:0] last_byte,
  output logic [7:0] starts,
  output logic [7:0] stops
);
  logic [7:0] shift = 8'h00;
  int bit_cnt = 0;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    last_byte = 8'h00;
    starts = 8'h00;
    stops = 8'h00;
  end
  // A data edge while the clock line is high frames a transfer.
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bit_cnt = 0;
      starts = starts + 8'h01;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stops = stops + 8'h01;
    end
  end
  always @(posedge scl) begin
    if (bit_cnt < 8) begin
      shift = {shift[6:0], sda};
    end
    bit_cnt = bit_cnt + 1;
    if (bit_cnt == 8) begin
      last_byte = shift;
    end
  end
  // The acknowledge goes out after the eighth bit; a slow slave then holds the clock low for 1600 ns.
  always @(negedge scl) begin
    if (bit_cnt == 8) begin
      sda_oe_n = nack;
      if (stretch) begin
        scl_oe_n = 1'b0;
        #1600;
        scl_oe_n = 1'b1;
      end
    end else if (bit_cnt == 9) begin
      sda_oe_n = 1'b1;
      bit_cnt = 0;
    end
  end
endmodule

// >>> bench/twm_master_test.sv
// Self-checking bench of the two-wire master transmitter.
`timescale 1ns/10ps
module twm_master_test;
  localparam logic [7:0] CT = twm_pkg::OFS_CTRL;
  localparam logic [7:0] DT = twm_pkg::OFS_DATA;
  localparam logic [7:0] ST = twm_pkg::OFS_STATUS;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_oe_n, sda_oe_n, irq, s_scl_oe_n, s_sda_oe_n;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  logic grab = 1'b0;
  logic [7:0] last_byte, starts, stops;
  logic scl_out, sda_out;
  wire scl = (scl_oe_n | scl_out) & s_scl_oe_n;
  wire sda = (sda_oe_n | sda_out) & s_sda_oe_n & ~grab;
  int fails = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  twm_master #(.QUARTER_CYC(2)) u_twm_master (.CLK(clk), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE_N(scl_oe_n),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .IRQ(irq));
  twm_slave_model u_twm_slave_model (.scl(scl), .sda(sda), .nack(nack), .stretch(stretch),
    .scl_oe_n(s_scl_oe_n), .sda_oe_n(s_sda_oe_n), .last_byte(last_byte), .starts(starts),
    .stops(stops));
  // ==========================================================================
  // Bus and compare tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t ns %s: got %h, expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(8'h00, 8'h01, "no ready");
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string m);
    logic [7:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, x, m);
  endtask
  // Reads until the masked bits match, giving up after 400 reads.
  task automatic poll(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 8'h00, r, e);
      n++;
    end while ((r & mk) !== x && n < 400);
    chk(r & mk, x, "poll");
  endtask
  task automatic flag(input logic [7:0] x);
    logic [7:0] r;
    logic e;
    poll(CT, 8'h80, 8'h80);
    apb(1'b0, ST, 8'h00, r, e);
    chk(r & 8'hF8, x, "status");
  endtask
  task automatic go(input logic [7:0] adr, input logic [7:0] x);
    wr(CT, 8'hA4);
    flag(twm_pkg::STAT_START);
    wr(DT, adr);
    wr(CT, 8'h84);
    flag(x);
  endtask
  task automatic stop_bus();
    wr(CT, 8'h94);
    poll(CT, 8'h10, 8'h00);
    repeat (4) @(posedge clk);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    logic [7:0] r;
    logic e;
    rd(CT, 8'h00, "ctrl reset");
    rd(DT, twm_pkg::DATA_RESET, "data reset");
    rd(ST, twm_pkg::STAT_NONE, "status reset");
    apb(1'b1, 8'h0C, 8'h55, r, e);
    chk({7'h0, e}, 8'h01, "unmapped");
    wr(DT, 8'h33);
    rd(CT, 8'h08, "collision");
    rd(DT, twm_pkg::DATA_RESET, "discarded");
    $display("t_regs done");
  endtask
  task automatic t_send();
    logic [7:0] s0;
    wr(CT, 8'hA5);
    flag(twm_pkg::STAT_START);
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h01, "irq on");
    repeat (40) @(posedge clk);
    chk({7'h0, scl_oe_n}, 8'h00, "clock held");
    wr(DT, 8'hA0);
    rd(CT, 8'hA5, "collision cleared");
    wr(CT, 8'h84);
    flag(twm_pkg::STAT_AW_ACK);
    chk(last_byte, 8'hA0, "address");
    chk({7'h0, irq}, 8'h00, "irq masked");
    stretch <= 1'b1;
    wr(DT, 8'h5A);
    wr(CT, 8'h84);
    flag(twm_pkg::STAT_DW_ACK);
    chk(last_byte, 8'h5A, "data");
    stretch <= 1'b0;
    s0 = stops;
    stop_bus();
    chk(stops, s0 + 8'h01, "stop seen");
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03, "released");
    $display("t_send done");
  endtask
  task automatic t_nack();
    logic [7:0] s0;
    nack <= 1'b1;
    go(8'hA2, twm_pkg::STAT_AW_NACK);
    wr(DT, 8'hC3);
    wr(CT, 8'h84);
    flag(twm_pkg::STAT_DW_NACK);
    s0 = stops;
    wr(CT, 8'hA4);
    flag(twm_pkg::STAT_RSTART);
    wr(DT, 8'hA3);
    wr(CT, 8'h84);
    flag(twm_pkg::STAT_AR_NACK);
    chk(stops, s0, "no stop");
    chk(last_byte, 8'hA3, "read address");
    stop_bus();
    nack <= 1'b0;
    $display("t_nack done");
  endtask
  task automatic t_both();
    logic [7:0] s0;
    go(8'hA0, twm_pkg::STAT_AW_ACK);
    s0 = stops;
    wr(CT, 8'hB4);
    flag(twm_pkg::STAT_START);
    chk(stops, s0 + 8'h01, "stop first");
    rd(CT, 8'hA4, "stop bit");
    stop_bus();
    $display("t_both done");
  endtask
  task automatic t_arb();
    logic [7:0] s0;
    wr(CT, 8'hA4);
    flag(twm_pkg::STAT_START);
    wr(DT, 8'hA0);
    grab <= 1'b1;
    wr(CT, 8'h84);
    flag(twm_pkg::STAT_LOST);
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03, "lost released");
    s0 = starts;
    wr(CT, 8'hA4);
    repeat (40) @(posedge clk);
    chk(starts, s0, "waits busy");
    grab <= 1'b0;
    flag(twm_pkg::STAT_START);
    stop_bus();
    $display("t_arb done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_send();
    t_nack();
    t_both();
    t_arb();
    finish_test();
  end
  initial begin
    #4000000;
    fails++;
    $display("[FAIL] %0t ns watchdog expired", $time);
    finish_test();
  end
endmodule
